// file: logic/pcc_pkg.sv
/*
  Package for the preset counter: widths, reset values and timing counts.
  Assumes a 50 MHz system clock.
*/
package pcc_pkg;
  localparam int PCC_CLK_HZ = 50000000;
  localparam int PCC_PV_W = 24;
  localparam logic [23:0] PCC_PV_MAX = 24'hF423F;
  localparam logic [23:0] PCC_OVF_PATTERN = 24'hFFFFFF;
  localparam logic [23:0] PCC_PV_RESET = 24'h000000;
  localparam logic [15:0] PCC_BATCH_RESET = 16'h0000;
  localparam logic [7:0] PCC_PRESCALE_RESET = 8'h01;
  // Reset must be at least this long before it takes effect
  localparam int PCC_RESET_MIN_US = 1000;
  localparam int PCC_RESET_MIN_CYC =
    (PCC_RESET_MIN_US * (PCC_CLK_HZ / 1000000));
  // Output delay after the present value passes the set value
  localparam int PCC_OUT_DLY_US = 200;
  localparam int PCC_OUT_DLY_CYC =
    (PCC_OUT_DLY_US * (PCC_CLK_HZ / 1000000));
  // Highest count rate in batch operation
  localparam int PCC_MAX_COUNT_HZ = 5000;
  localparam int PCC_MIN_PULSE_CYC = PCC_CLK_HZ / PCC_MAX_COUNT_HZ;
endpackage

// file: logic/pcc_delay.sv
/*
  Delay counter: reports a level once its input has been steadily high
  for CYCLES clocks. Assumes inputs synchronous to clk.
*/
`timescale 1ns/1ns
module pcc_delay #(
  parameter int CYCLES = 50000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Level in, delayed level out
  input wire logic level_in,
  output logic level_out
);
  localparam int CW = $clog2(CYCLES + 1);
  // Elaboration check: a zero count would pass the level straight through
  if (CYCLES < 1) begin : g_bad_cycles
    $error("pcc_delay: CYCLES must be at least one");
  end
  logic [CW-1:0] cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (!level_in) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(CYCLES)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign level_out = level_in && (cnt_q == CW'(CYCLES));
endmodule

// file: logic/pcc_counter.sv
/*
  Preset counter with prescaling, overflow handling and batch count.
  Assumes count pulses and the reset pin are synchronous to clk, and that
  each count pulse is a one-cycle strobe no faster than 5 kHz.
*/
// Contract
// [RQ1] Output on when set value and present value are both zero.
// [RQ2] Output held off while the reset input is in progress.
// [RQ3] Set value at or above maximum minus prescale never compares true.
// [RQ4] Overflow shows the all-ones pattern and forces the output on.
// [RQ5] Batch count counts set-value arrivals; pulses up to 5 kHz served.
// [RQ6] Reset held its minimum width clears the output within bounds.
// [RQ7] Output follows the set-value passing within the reference delay.
// [RQ8] Comparison is continuous; a changed set value acts at once.
// [RQ9] Each count pulse adds the prescale factor; overflow saturates.
`timescale 1ns/1ns
module pcc_counter
  import pcc_pkg::*;
#(
  parameter int PV_W = PCC_PV_W,
  parameter logic [23:0] PV_MAX = PCC_PV_MAX,
  parameter int RESET_CYC = PCC_RESET_MIN_CYC,
  parameter int OUT_CYC = PCC_OUT_DLY_CYC
) (
  // Clock and system reset
  input wire logic clk,
  input wire logic resetn,
  // Sensor and external reset pin
  input wire logic count_pulse,
  input wire logic ext_reset,
  // Configuration
  input wire logic [23:0] set_value,
  input wire logic [7:0] prescale_factor,
  // State and control output
  output logic [23:0] present_value,
  output logic overflow,
  output logic [15:0] batch_count,
  output logic control_out
);
  // Elaboration checks: the overflow pattern assumes a 24-bit value
  if (PV_W != 24) begin : g_bad_width
    $error("pcc_counter: only a 24-bit present value is supported");
  end
  if (RESET_CYC < 1 || OUT_CYC < 1) begin : g_bad_delay
    $error("pcc_counter: delay counts must be at least one");
  end
  if (PV_MAX == PCC_OVF_PATTERN || PV_MAX < 24'h0000FF) begin : g_bad_max
    $error("pcc_counter: range top unusable for prescale or overflow");
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset qualification and compare

  logic reset_active;
  logic [24:0] sum;
  logic [24:0] limit;
  logic reached;
  logic cmp_on;
  logic cmp_dly;
  logic [23:0] pv_q;
  logic ovf_q;
  logic [15:0] batch_q;
  logic out_q;
  logic reached_q;

  // Short glitches on the reset pin are ignored by the count until its minimum width; control_out drops on the next clock
  pcc_delay #(.CYCLES(RESET_CYC)) u_reset_dly (
    .clk(clk),
    .resetn(resetn),
    .level_in(ext_reset),
    .level_out(reset_active)
  );

  assign sum = {1'b0, pv_q} + {17'h00000, prescale_factor};
  // Top of range minus prescale; set values at or above it never match
  assign limit = {1'b0, PV_MAX} - {17'h00000, prescale_factor};
  assign reached = ({1'b0, set_value} < limit) && // RQ3
                   (pv_q >= set_value) && (set_value != 24'h000000);
  // Comparison reads set_value every cycle, so a change acts at once
  assign cmp_on = ovf_q || reached || // RQ4 RQ8
                  (set_value == 24'h000000 && pv_q == 24'h000000); // RQ1

  // Output filter stands for the reference delay of the transistor stage
  pcc_delay #(.CYCLES(OUT_CYC)) u_out_dly (
    .clk(clk),
    .resetn(resetn),
    .level_in(cmp_on),
    .level_out(cmp_dly)
  );

  ////////////////////////////////////////////////////////////////////////
  // Present value

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pv_q <= PCC_PV_RESET;
      ovf_q <= 1'b0;
    end else if (reset_active) begin
      pv_q <= PCC_PV_RESET;
      ovf_q <= 1'b0;
    end else if (count_pulse && !ovf_q) begin
      if (sum > {1'b0, PV_MAX}) begin
        pv_q <= PCC_OVF_PATTERN; // RQ9 RQ4
        ovf_q <= 1'b1;
      end else begin
        pv_q <= sum[23:0]; // RQ9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Batch count: one per rising edge of the match

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reached_q <= 1'b0;
      batch_q <= PCC_BATCH_RESET;
    end else begin
      reached_q <= reached;
      if (reached && !reached_q && batch_q != 16'hFFFF) begin
        batch_q <= batch_q + 16'h0001; // RQ5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control output

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 1'b0;
    end else if (reset_active || ext_reset) begin
      out_q <= 1'b0; // RQ2 RQ6
    end else begin
      out_q <= cmp_dly; // RQ7
    end
  end

  assign present_value = pv_q;
  assign overflow = ovf_q;
  assign batch_count = batch_q;
  assign control_out = out_q;

  ////////////////////////////////////////////////////////////////////////
  // Check helper: cycles the compare has held with the reset pin low

  localparam int RUN_W = $clog2(OUT_CYC + 2);
  logic [RUN_W-1:0] run_q;
  logic run_full;

  // A counter keeps the delay check cheap even at the full default count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= '0;
    end else if (!cmp_on || ext_reset) begin
      run_q <= '0;
    end else if (!run_full) begin
      run_q <= run_q + 1'b1;
    end
  end
  assign run_full = (run_q == RUN_W'(OUT_CYC + 1));

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_reset_held;
    ext_reset [*2];
  endsequence

  AST_ZERO_ON: assert property (@(posedge clk) disable iff (!resetn) // RQ1
    (set_value == 24'h000000 && present_value == 24'h000000 && run_full)
      |-> control_out)
    else $error("output not on with zero set and present values");

  AST_RESET_OFF: assert property (@(posedge clk) disable iff (!resetn) // RQ2
    s_reset_held |-> !control_out)
    else $error("output on during reset");

  AST_PRESCALE_LIMIT: assert property (@(posedge clk) // RQ3
    disable iff (!resetn)
    ({1'b0, set_value} >= limit && !ovf_q && set_value != 24'h000000)
      |-> !cmp_on)
    else $error("compare true above the prescale limit");

  AST_OVF_PATTERN: assert property (@(posedge clk) disable iff (!resetn) // RQ4
    overflow |-> present_value == PCC_OVF_PATTERN && cmp_on)
    else $error("overflow without pattern or output request");

  AST_BATCH_STEP: assert property (@(posedge clk) disable iff (!resetn) // RQ5
    (reached && !reached_q && batch_count != 16'hFFFF) |=>
      batch_count == $past(batch_count) + 16'h0001)
    else $error("batch count did not advance");

  AST_RESET_CLEARS: assert property (@(posedge clk) // RQ6
    disable iff (!resetn)
    reset_active |=> present_value == PCC_PV_RESET && !overflow)
    else $error("reset did not clear present value");

  AST_SET_CHANGE: assert property (@(posedge clk) disable iff (!resetn) // RQ8
    (set_value != $past(set_value) && set_value == present_value &&
     {1'b0, set_value} < limit && set_value != 24'h000000) |-> cmp_on)
    else $error("changed set value did not compare at once");

  AST_PRESCALE_STEP: assert property (@(posedge clk) // RQ9
    disable iff (!resetn)
    (count_pulse && !overflow && !reset_active &&
     sum <= {1'b0, PV_MAX}) |=> present_value == $past(sum[23:0]))
    else $error("present value did not advance by the prescale factor");

  AST_RESET_DROP: assert property (@(posedge clk) // RQ2
    disable iff (!resetn)
    ext_reset |=> !control_out)
    else $error("output still on one cycle after the reset pin rose");

  AST_OUT_DELAY: assert property (@(posedge clk) // RQ7
    disable iff (!resetn)
    run_full |-> control_out)
    else $error("output late after the compare became true");

  AST_OUT_RISE: assert property (@(posedge clk) // RQ7
    disable iff (!resetn)
    $rose(control_out) |-> $past(cmp_dly))
    else $error("output rose before the delay ran out");

  AST_BATCH_HOLD: assert property (@(posedge clk) // RQ5
    disable iff (!resetn)
    !(reached && !reached_q) |=> $stable(batch_count))
    else $error("batch count moved without a new arrival");
endmodule

// file: test/pcc_sensor_model.sv
/*
  Sensor model: emits a burst of one-cycle count pulses with a fixed
  idle gap between them. Assumes the bench starts a burst only when idle.
*/
`timescale 1ns/1ns
module pcc_sensor_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Burst request
  input wire logic start,
  input wire logic [15:0] n_pulses,
  input wire logic [7:0] gap,
  // Sensor line and status
  output logic count_pulse,
  output logic busy
);
  logic [15:0] left_q;
  logic [7:0] wait_q;
  // Gap of at least one idle cycle keeps pulses distinct strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_q <= 16'h0000;
      wait_q <= 8'h00;
      count_pulse <= 1'b0;
    end else begin
      count_pulse <= 1'b0;
      if (start && left_q == 16'h0000) begin
        left_q <= n_pulses;
        wait_q <= 8'h00;
      end else if (left_q != 16'h0000) begin
        if (wait_q == 8'h00) begin
          count_pulse <= 1'b1;
          left_q <= left_q - 16'h0001;
          wait_q <= gap;
        end else begin
          wait_q <= wait_q - 8'h01;
        end
      end
    end
  end
  assign busy = (left_q != 16'h0000) || count_pulse;
endmodule

// file: test/preset_counter_compare_tb.sv
/*
  Self-checking bench for the preset counter.
  Assumes shortened reset width 4 and output delay 3 cycles.
*/
`timescale 1ns/1ns
module preset_counter_compare_tb;
  import pcc_pkg::*;
  logic clk, resetn, ext_reset, start, count_pulse, busy, overflow;
  logic control_out;
  logic [23:0] set_value, present_value;
  logic [7:0] prescale_factor;
  logic [15:0] batch_count, b;
  int bad_count = 0;
  int n_checks = 0;
  logic [15:0] np;
  logic [7:0] gp;
  pcc_sensor_model sens (.clk(clk), .resetn(resetn), .start(start),
    .n_pulses(np), .gap(gp), .count_pulse(count_pulse), .busy(busy));
  pcc_counter #(.RESET_CYC(4), .OUT_CYC(3)) dut (.clk(clk),
    .resetn(resetn), .count_pulse(count_pulse), .ext_reset(ext_reset),
    .set_value(set_value), .prescale_factor(prescale_factor),
    .present_value(present_value), .overflow(overflow),
    .batch_count(batch_count), .control_out(control_out));
  //////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Bounded wait for the output level; timing is a reference figure
  task wait_out(input logic e, input int lim);
    int i;
    for (i = 0; i < lim && control_out !== e; i++) @(negedge clk);
    chk("control_out", {23'h0, e}, {23'h0, control_out});
  endtask
  task send(input logic [15:0] n, input logic [7:0] g);
    int i;
    @(posedge clk) begin np <= n; gp <= g; start <= 1'b1; end
    @(posedge clk) start <= 1'b0;
    // The model takes the request at this edge; busy shows only after it
    @(negedge clk);
    for (i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge clk);
    if (busy === 1'b0) begin
      repeat (2) @(negedge clk);
    end else begin
      bad_count++;
      results();
    end
  endtask
  task ext_clear;
    @(posedge clk) ext_reset <= 1'b1;
    wait_out(1'b0, 3);
    repeat (8) @(negedge clk);
    chk("control_out", 24'h0, {23'h0, control_out});
    chk("present_value", 24'h0, present_value);
    @(posedge clk) ext_reset <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Both values zero after reset: output on, then cleared by the pin
  task zero_case;
    wait_out(1'b1, 20);
    ext_clear();
  endtask
  // Prescaled counting up to the set value, one batch arrival
  task prescale_batch;
    b = batch_count;
    @(posedge clk) begin
      set_value <= 24'h000009;
      prescale_factor <= 8'h03;
    end
    send(16'h0003, 8'h04);
    chk("present_value", 24'h000009, present_value);
    wait_out(1'b1, 20);
    chk("batch_count", {8'h0, b + 16'h0001}, {8'h0, batch_count});
    ext_clear();
  endtask
  // Set value lowered onto the present value acts at once
  task set_change;
    @(posedge clk) set_value <= 24'h000014;
    send(16'h0002, 8'h02);
    chk("present_value", 24'h000006, present_value);
    repeat (6) @(negedge clk);
    chk("control_out", 24'h0, {23'h0, control_out});
    @(posedge clk) set_value <= 24'h000006;
    wait_out(1'b1, 20);
    chk("batch_count", 24'h000002, {8'h0, batch_count});
    ext_clear();
  endtask
  // Set value at the prescale limit never compares; overflow forces on
  task limit_overflow;
    @(posedge clk) begin
      set_value <= 24'hF4140;
      prescale_factor <= 8'hFF;
    end
    send(16'h0F51, 8'h01);
    chk("present_value", 24'h0F41AF, present_value);
    repeat (10) @(negedge clk);
    chk("control_out", 24'h0, {23'h0, control_out});
    send(16'h0001, 8'h01);
    chk("present_value", PCC_OVF_PATTERN, present_value);
    chk("overflow", 24'h1, {23'h0, overflow});
    wait_out(1'b1, 20);
    send(16'h0001, 8'h01);
    chk("present_value", PCC_OVF_PATTERN, present_value);
    chk("batch_count", 24'h000002, {8'h0, batch_count});
  endtask
  initial begin
    resetn = 1'b0;
    ext_reset = 1'b0;
    start = 1'b0;
    np = 16'h0000;
    gp = 8'h01;
    set_value = 24'h000000;
    prescale_factor = 8'h01;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    zero_case();
    prescale_batch();
    set_change();
    limit_overflow();
    results();
  end
endmodule
